/* File: rtl/mspwm_cfg.svh */
// Register map, field positions, reset values and widths for the multi-slave PWM timer
`ifndef MSPWM_CFG_SVH
`define MSPWM_CFG_SVH
`define MSPWM_AW              4
`define MSPWM_DW              16
`define MSPWM_ADDR_UNIT_EN    4'h0
`define MSPWM_ADDR_START      4'h1
`define MSPWM_ADDR_STOP       4'h2
`define MSPWM_ADDR_ENSTAT     4'h3
`define MSPWM_ADDR_MODE0      4'h4
`define MSPWM_ADDR_OUTVAL     4'h7
`define MSPWM_ADDR_OUTEN      4'h8
`define MSPWM_ADDR_OUTPOL     4'h9
`define MSPWM_ADDR_OUTMODE    4'ha
`define MSPWM_ADDR_DATA0      4'hb
`define MSPWM_ADDR_CNT0       4'he
`define MSPWM_NCH             3
`define MSPWM_CH_MASTER       0
`define MSPWM_CH_S1           1
`define MSPWM_CH_S2           2
`define MSPWM_ZERO16          16'h0000
`define MSPWM_ONE16           16'h0001
`define MSPWM_TRIG_MASK       16'h0007
`endif

/* File: rtl/mspwm_pkg.sv */
// Types shared by the multi-slave PWM timer modules
package mspwm_pkg;
	typedef logic [15:0] mspwm_word_t;
	typedef enum logic [1:0] {
		MSPWM_IDLE,
		MSPWM_RUN,
		MSPWM_DONE
	} mspwm_slave_st_t;
endpackage

/* File: rtl/mspwm_trig_if.sv */
// Interface carrying the master period event and run state to the slave channels
`timescale 1ns/10ps
`default_nettype none
interface mspwm_trig_if;
	logic master_period_interrupt;
	logic running;
	logic unit_clear;
	modport src (output master_period_interrupt, output running, output unit_clear);
	modport snk (input master_period_interrupt, input running, input unit_clear);
endinterface
`default_nettype wire

/* File: rtl/mspwm_slave.sv */
// One-count slave channel: reloads duty on the master event and times the active phase
`timescale 1ns/10ps
`include "mspwm_cfg.svh"
`default_nettype none
module mspwm_slave (
	input  wire logic                ref_clk_i,
	input  wire logic                srst_i,
	mspwm_trig_if.snk                trig,
	input  wire mspwm_pkg::mspwm_word_t duty_i,
	output var  mspwm_pkg::mspwm_word_t count_o,
	output var  logic                active_o
);
	mspwm_pkg::mspwm_slave_st_t state_ff;
	mspwm_pkg::mspwm_word_t     count_ff;
	logic                       active_ff;
	wire                        at_zero = (count_ff == `MSPWM_ZERO16);

	assign count_o  = count_ff;
	assign active_o = active_ff;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || trig.unit_clear) begin
			state_ff  <= mspwm_pkg::MSPWM_IDLE;
			count_ff  <= `MSPWM_ZERO16;
			active_ff <= 1'b0;
		end else if (trig.running) begin
			if (trig.master_period_interrupt) begin
				// Restart even mid-count; the output goes active unless the new duty is zero
				count_ff  <= duty_i;
				state_ff  <= mspwm_pkg::MSPWM_RUN;
				active_ff <= (duty_i != `MSPWM_ZERO16);
			end else begin
				unique case (state_ff)
					mspwm_pkg::MSPWM_RUN: begin
						if (at_zero || count_ff == `MSPWM_ONE16) begin
							// Count at one (or zero) ends the active phase until the next reload
							count_ff  <= `MSPWM_ZERO16;
							active_ff <= 1'b0;
							state_ff  <= mspwm_pkg::MSPWM_DONE;
						end else begin
							count_ff <= count_ff - `MSPWM_ONE16;
						end
					end
					mspwm_pkg::MSPWM_IDLE,
					mspwm_pkg::MSPWM_DONE: begin
						state_ff <= state_ff;
					end
				endcase
			end
		end
	end
endmodule // mspwm_slave
`default_nettype wire

/* File: rtl/mspwm_top.sv */
// Multi-slave PWM timer: master interval channel, two one-count slaves, register port
`timescale 1ns/10ps
`include "mspwm_cfg.svh"
`default_nettype none
module mspwm_top (
	input  wire logic                    ref_clk_i,
	input  wire logic                    srst_i,
	input  wire logic [`MSPWM_AW-1:0]    addr_i,
	input  wire logic [`MSPWM_DW-1:0]    wdata_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output logic      [`MSPWM_DW-1:0]    rdata_o,
	output logic                         master_period_interrupt_o,
	output logic      [1:0]              slave_output_pin_o,
	output logic      [1:0]              slave_output_oe_o
);
	mspwm_trig_if trig ();

	logic                   unit_en_ff;
	logic                   running_ff;
	logic                   mevt_ff;
	mspwm_pkg::mspwm_word_t mode_ff [`MSPWM_NCH];
	mspwm_pkg::mspwm_word_t data_ff [`MSPWM_NCH];
	mspwm_pkg::mspwm_word_t mcount_ff;
	mspwm_pkg::mspwm_word_t outval_ff;
	mspwm_pkg::mspwm_word_t outen_ff;
	mspwm_pkg::mspwm_word_t outpol_ff;
	mspwm_pkg::mspwm_word_t outmode_ff;
	logic [`MSPWM_DW-1:0]   rdata_ff;
	logic [1:0]             pin_ff;
	logic [1:0]             oe_ff;
	logic                   mevt_out_ff;
	mspwm_pkg::mspwm_word_t s1_count;
	mspwm_pkg::mspwm_word_t s2_count;
	logic                   s1_active;
	logic                   s2_active;

	// Strobe and address are arguments, so continuous assignments see them change
	function automatic logic wr_hit(
		input logic                 w,
		input logic [`MSPWM_AW-1:0] addr,
		input logic [`MSPWM_AW-1:0] a
	);
		wr_hit = w && (addr == a);
	endfunction

	// Writes other than to the unit enable register are ignored while the unit is disabled
	wire wr_en      = unit_en_ff;
	wire wr_unit    = wr_hit(wr_i, addr_i, `MSPWM_ADDR_UNIT_EN);
	wire start_hit  = wr_en && wr_hit(wr_i, addr_i, `MSPWM_ADDR_START) && (wdata_i[2:0] != 3'h0);
	wire stop_hit   = wr_en && wr_hit(wr_i, addr_i, `MSPWM_ADDR_STOP) && (wdata_i[2:0] != 3'h0);
	wire unit_clear = wr_unit && !wdata_i[0];
	wire m_zero     = (mcount_ff == `MSPWM_ZERO16);
	wire cfg_wr     = wr_en && !running_ff;
	wire data_wr    = wr_en;
	wire [1:0] s_act = {s2_active, s1_active};
	wire [1:0] drive = s_act ^ outpol_ff[2:1];
	wire [1:0] en2   = outen_ff[2:1];

	assign trig.master_period_interrupt = mevt_ff;
	assign trig.running                 = running_ff;
	assign trig.unit_clear              = unit_clear;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || unit_clear) begin
			unit_en_ff <= srst_i ? 1'b0 : 1'b0;
		end else if (wr_unit) begin
			unit_en_ff <= wdata_i[0];
		end
	end

	// Start and stop are trigger writes; nothing stores them
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || unit_clear) begin
			running_ff <= 1'b0;
		end else if (stop_hit) begin
			running_ff <= 1'b0;
		end else if (start_hit) begin
			running_ff <= 1'b1;
		end
	end

	// Master interval counter; the event fires as counting starts and at each zero
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || unit_clear) begin
			mcount_ff <= `MSPWM_ZERO16;
			mevt_ff   <= 1'b0;
		end else if (start_hit && !running_ff) begin
			mcount_ff <= data_ff[`MSPWM_CH_MASTER];
			mevt_ff   <= 1'b1;
		end else if (running_ff && !stop_hit) begin
			if (m_zero) begin
				mcount_ff <= data_ff[`MSPWM_CH_MASTER];
				mevt_ff   <= 1'b1;
			end else begin
				mcount_ff <= mcount_ff - `MSPWM_ONE16;
				mevt_ff   <= 1'b0;
			end
		end else begin
			mevt_ff <= 1'b0;
		end
	end

	// Mode, polarity and output mode are taken only while stopped; data, output value and output enable at any time
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || unit_clear) begin
			for (int i = 0; i < `MSPWM_NCH; i++) begin
				mode_ff[i] <= `MSPWM_ZERO16;
				data_ff[i] <= `MSPWM_ZERO16;
			end
			outval_ff  <= `MSPWM_ZERO16;
			outen_ff   <= `MSPWM_ZERO16;
			outpol_ff  <= `MSPWM_ZERO16;
			outmode_ff <= `MSPWM_ZERO16;
		end else begin
			for (int i = 0; i < `MSPWM_NCH; i++) begin
				if (cfg_wr && wr_hit(wr_i, addr_i, `MSPWM_ADDR_MODE0 + 4'(i))) begin
					mode_ff[i] <= wdata_i;
				end
				if (data_wr && wr_hit(wr_i, addr_i, `MSPWM_ADDR_DATA0 + 4'(i))) begin
					data_ff[i] <= wdata_i;
				end
			end
			if (wr_en && wr_hit(wr_i, addr_i, `MSPWM_ADDR_OUTVAL)) begin
				outval_ff <= wdata_i;
			end
			if (wr_en && wr_hit(wr_i, addr_i, `MSPWM_ADDR_OUTEN)) begin
				outen_ff <= wdata_i;
			end
			if (cfg_wr && wr_hit(wr_i, addr_i, `MSPWM_ADDR_OUTPOL)) begin
				outpol_ff <= wdata_i;
			end
			if (cfg_wr && wr_hit(wr_i, addr_i, `MSPWM_ADDR_OUTMODE)) begin
				outmode_ff <= wdata_i;
			end
		end
	end

	mspwm_slave u_slave1 (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.trig      (trig),
		.duty_i    (data_ff[`MSPWM_CH_S1]),
		.count_o   (s1_count),
		.active_o  (s1_active)
	);

	mspwm_slave u_slave2 (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.trig      (trig),
		.duty_i    (data_ff[`MSPWM_CH_S2]),
		.count_o   (s2_count),
		.active_o  (s2_active)
	);

	// Pins: counting drives them when enabled in output mode and running, and holds them while stopped; otherwise the value bit
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || unit_clear) begin
			pin_ff <= 2'h0;
			oe_ff  <= 2'h0;
		end else begin
			oe_ff <= {unit_en_ff, unit_en_ff};
			for (int k = 0; k < 2; k++) begin
				if (en2[k] && outmode_ff[k+1]) begin
					if (running_ff) begin
						pin_ff[k] <= drive[k];
					end else begin
						pin_ff[k] <= pin_ff[k];
					end
				end else begin
					pin_ff[k] <= outval_ff[k+1];
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			mevt_out_ff <= 1'b0;
		end else begin
			mevt_out_ff <= mevt_ff;
		end
	end

	// Read mux; addresses not listed (start, stop) fall to the slave 2 count and are zeroed at the read register
	logic [`MSPWM_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = `MSPWM_ZERO16;
		unique case (addr_i)
			`MSPWM_ADDR_UNIT_EN: rd_mux = {15'h0, unit_en_ff};
			`MSPWM_ADDR_ENSTAT:  rd_mux = {13'h0, {3{running_ff}}};
			4'h4:                rd_mux = mode_ff[0];
			4'h5:                rd_mux = mode_ff[1];
			4'h6:                rd_mux = mode_ff[2];
			`MSPWM_ADDR_OUTVAL:  rd_mux = outval_ff;
			`MSPWM_ADDR_OUTEN:   rd_mux = outen_ff;
			`MSPWM_ADDR_OUTPOL:  rd_mux = outpol_ff;
			`MSPWM_ADDR_OUTMODE: rd_mux = outmode_ff;
			4'hb:                rd_mux = data_ff[0];
			4'hc:                rd_mux = data_ff[1];
			4'hd:                rd_mux = data_ff[2];
			`MSPWM_ADDR_CNT0:    rd_mux = mcount_ff;
			4'hf:                rd_mux = s1_count;
			default:             rd_mux = s2_count;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rdata_ff <= `MSPWM_ZERO16;
		end else if (rd_i) begin
			rdata_ff <= (addr_i == `MSPWM_ADDR_START || addr_i == `MSPWM_ADDR_STOP)
				? `MSPWM_ZERO16 : rd_mux;
		end else begin
			rdata_ff <= `MSPWM_ZERO16;
		end
	end

	assign rdata_o                   = rdata_ff;
	assign master_period_interrupt_o = mevt_out_ff;
	assign slave_output_pin_o        = pin_ff;
	assign slave_output_oe_o         = oe_ff;

	AST_MASTER_RELOAD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		running_ff && m_zero && !stop_hit && !unit_clear |=> mevt_ff
			&& mcount_ff == $past(data_ff[0]))
		else $error("Master did not reload at zero");
	AST_MASTER_DOWN: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		running_ff && !m_zero && !stop_hit && !unit_clear |=> !mevt_ff
			&& mcount_ff == $past(mcount_ff) - 16'h0001)
		else $error("Master did not count down");
	AST_START_EVT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		start_hit && !running_ff && !unit_clear |=> running_ff && mevt_ff)
		else $error("Start did not raise status and event");
	AST_STOP_HOLD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		stop_hit && !unit_clear |=> !running_ff ##1 ($past(start_hit) || $past(unit_clear)
			|| mcount_ff == $past(mcount_ff)))
		else $error("Stop did not hold the counter");
	AST_S1_LOAD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		mevt_ff && running_ff && !unit_clear |=> s1_count == $past(data_ff[1]))
		else $error("Slave 1 did not load its duty");
	AST_S2_LOAD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		mevt_ff && running_ff && !unit_clear |=> s2_count == $past(data_ff[2]))
		else $error("Slave 2 did not load its duty");
	AST_PIN_HOLD: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!running_ff && en2[0] && outmode_ff[1] && !unit_clear |=> $stable(pin_ff[0]))
		else $error("Pin changed while stopped");
	AST_POLARITY: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		running_ff && en2[0] && outmode_ff[1] && !unit_clear
			|=> pin_ff[0] == ($past(s1_active) ^ $past(outpol_ff[1])))
		else $error("Pin level does not follow polarity");
	AST_NO_WR_DIS: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!unit_en_ff && !wr_unit |=> $stable(outval_ff) && $stable(data_ff[0]))
		else $error("Write accepted while unit disabled");
	AST_UNIT_CLR: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		unit_clear |=> outval_ff == 16'h0000 && oe_ff == 2'h0 && !running_ff)
		else $error("Unit clear did not initialise");
endmodule // mspwm_top
`default_nettype wire

/* File: sim/mspwm_pin_probe.sv */
// Pin-side model: measures period and active cycles of both slave pins per master window
`timescale 1ns/10ps
`default_nettype none
module mspwm_pin_probe (
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	input  wire logic        irq_i,
	input  wire logic [1:0]  pin_i,
	input  wire logic [1:0]  pol_i,
	output logic      [15:0] period_o,
	output logic      [15:0] act1_o,
	output logic      [15:0] act2_o,
	output logic      [15:0] windows_o
);
	logic [15:0] cnt_ff;
	logic [15:0] acc1_ff;
	logic [15:0] acc2_ff;
	logic [1:0]  active;
	// Undo the polarity so both pins are counted in active cycles
	assign active = pin_i ^ pol_i;
	// Window runs from one event sample to the next, so the count is immune to
	// a one-cycle shift of the pin edges
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cnt_ff    <= 16'h0000;
			acc1_ff   <= 16'h0000;
			acc2_ff   <= 16'h0000;
			period_o  <= 16'h0000;
			act1_o    <= 16'h0000;
			act2_o    <= 16'h0000;
			windows_o <= 16'h0000;
		end else if (irq_i) begin // Each master event closes one window
			period_o  <= cnt_ff;
			act1_o    <= acc1_ff;
			act2_o    <= acc2_ff;
			windows_o <= windows_o + 16'h0001;
			cnt_ff    <= 16'h0001;
			acc1_ff   <= {15'h0000, active[0]};
			acc2_ff   <= {15'h0000, active[1]};
		end else begin
			cnt_ff  <= cnt_ff + 16'h0001;
			acc1_ff <= acc1_ff + {15'h0000, active[0]};
			acc2_ff <= acc2_ff + {15'h0000, active[1]};
		end
	end
endmodule // mspwm_pin_probe
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the multi-slave PWM timer
`timescale 1ns/10ps
`include "mspwm_cfg.svh"
`default_nettype none
module tb_top;
	logic                 ref_clk_i;
	logic                 srst_i;
	logic [`MSPWM_AW-1:0] addr_i;
	logic [`MSPWM_DW-1:0] wdata_i;
	logic                 wr_i;
	logic                 rd_i;
	logic [`MSPWM_DW-1:0] rdata_o;
	logic                 master_period_interrupt_o;
	logic [1:0]           slave_output_pin_o;
	logic [1:0]           slave_output_oe_o;
	logic [15:0]          period;
	logic [15:0]          act1;
	logic [15:0]          act2;
	logic [15:0]          windows;
	logic [15:0]          held_cnt;
	logic [15:0]          held_win;
	logic [1:0]           held_pin;
	int                   errors;
	int                   checks;

	mspwm_top mspwm_top_i (
		.ref_clk_i                 (ref_clk_i),
		.srst_i                    (srst_i),
		.addr_i                    (addr_i),
		.wdata_i                   (wdata_i),
		.wr_i                      (wr_i),
		.rd_i                      (rd_i),
		.rdata_o                   (rdata_o),
		.master_period_interrupt_o (master_period_interrupt_o),
		.slave_output_pin_o        (slave_output_pin_o),
		.slave_output_oe_o         (slave_output_oe_o)
	);

	// Slave 2 is set active-low below, so the probe is told the same
	mspwm_pin_probe mspwm_pin_probe_i (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.irq_i     (master_period_interrupt_o),
		.pin_i     (slave_output_pin_o),
		.pol_i     (2'b10),
		.period_o  (period),
		.act1_o    (act1),
		.act2_o    (act2),
		.windows_o (windows)
	);

	always #4 ref_clk_i = ~ref_clk_i;

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask

	// Bounded wait for the next master event; a lost event ends the run.
	// The event is sampled just past the edge, then one more edge lets the probe close its window
	task automatic wait_irq;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (master_period_interrupt_o !== 1'b1 && n < 64);
		if (master_period_interrupt_o !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
			wrap_up();
		end else begin
			@(posedge ref_clk_i);
			#1;
		end
	endtask

	initial begin
		ref_clk_i = 1'b0;
		srst_i    = 1'b1;
		addr_i    = 4'h0;
		wdata_i   = 16'h0000;
		wr_i      = 1'b0;
		rd_i      = 1'b0;
		errors    = 0;
		checks    = 0;
		repeat (5) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		wr_reg(`MSPWM_ADDR_OUTVAL, 16'h0006);
		wr_reg(`MSPWM_ADDR_UNIT_EN, 16'h0001);
		rd_chk(`MSPWM_ADDR_OUTVAL, 16'h0000);
		wr_reg(`MSPWM_ADDR_MODE0, 16'h0000);
		wr_reg(`MSPWM_ADDR_OUTMODE, 16'h0006);
		wr_reg(`MSPWM_ADDR_OUTPOL, 16'h0004);
		wr_reg(`MSPWM_ADDR_OUTVAL, 16'h0004);
		wr_reg(`MSPWM_ADDR_OUTEN, 16'h0006);
		wr_reg(`MSPWM_ADDR_DATA0, 16'h0009);
		wr_reg(`MSPWM_ADDR_DATA0 + 4'h1, 16'h0003);
		// Slave 2 duty above period plus one saturates at full period
		wr_reg(`MSPWM_ADDR_DATA0 + 4'h2, 16'h000c);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk({12'h000, slave_output_oe_o, slave_output_pin_o}, 16'h000e);
		wr_reg(`MSPWM_ADDR_START, 16'h0007);
		rd_chk(`MSPWM_ADDR_ENSTAT, 16'h0007);
		rd_chk(`MSPWM_ADDR_START, 16'h0000);
		repeat (3) wait_irq();
		chk(period, 16'h000a);
		chk(act1, 16'h0003);
		chk(act2, 16'h000a);
		wr_reg(`MSPWM_ADDR_OUTPOL, 16'h0000);
		rd_chk(`MSPWM_ADDR_OUTPOL, 16'h0004);
		wait_irq();
		wr_reg(`MSPWM_ADDR_DATA0 + 4'h1, 16'h0005);
		repeat (2) wait_irq();
		chk(act1, 16'h0005);
		wr_reg(`MSPWM_ADDR_STOP, 16'h0007);
		rd_chk(`MSPWM_ADDR_ENSTAT, 16'h0000);
		rd_reg(`MSPWM_ADDR_CNT0, held_cnt);
		held_win = windows;
		held_pin = slave_output_pin_o;
		repeat (20) @(posedge ref_clk_i);
		rd_chk(`MSPWM_ADDR_CNT0, held_cnt);
		chk(windows, held_win);
		chk({14'h0000, slave_output_pin_o}, {14'h0000, held_pin});
		wr_reg(`MSPWM_ADDR_OUTEN, 16'h0000);
		// Idle level differs from the held level so a stuck pin is caught
		wr_reg(`MSPWM_ADDR_OUTVAL, 16'h0004);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk({14'h0000, slave_output_pin_o}, 16'h0002);
		wr_reg(`MSPWM_ADDR_UNIT_EN, 16'h0000);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk({12'h000, slave_output_oe_o, slave_output_pin_o}, 16'h0000);
		wr_reg(`MSPWM_ADDR_UNIT_EN, 16'h0001);
		rd_chk(`MSPWM_ADDR_OUTVAL, 16'h0000);
		rd_chk(`MSPWM_ADDR_DATA0, 16'h0000);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
